// ===== core/dft_stream.sv
`timescale 1ns/10ps
// Function
// - Forward or inverse DFT on complex samples
// - Length chosen per transform from 53
// - Transforms accepted back to back, no gap
// - Never stalls input; no ready signal, a transform is dropped when both banks are full
// - Empty-pipeline latency depends only on length
// - Pipeline overhead equal for every length
// - Results leave strictly in input order
// - Command: 6-bit index, bit 6 direction
// - Command sampled only with start marker
// - Invalid cycles mid-transform are skipped
module dft_stream (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire dft_pkg::in_beat_s in_i,
  output dft_pkg::out_beat_s out_o,
  output logic drop_o
);
  localparam int AW = dft_pkg::LEN_W + 1;

  logic [2*dft_pkg::DATA_W-1:0] frame_mem [0:(2**AW)-1];

  logic wr_active_q;
  logic wr_drop_q;
  logic wr_bank_q;
  dft_pkg::len_t wr_addr_q;
  dft_pkg::len_t wr_len_q;
  dft_pkg::cmd_t wr_cmd_q;
  logic [dft_pkg::BANKS-1:0] bank_full_q;
  dft_pkg::cmd_t bank_cmd_q [dft_pkg::BANKS];

  logic take;
  logic start;
  logic frame_done;
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  dft_pkg::len_t start_len;

  dft_pkg::eng_state_e state_q;
  logic rd_bank_q;
  dft_pkg::len_t n_q;
  dft_pkg::len_t k_q;
  dft_pkg::len_t rd_len_q;
  dft_pkg::cmd_t rd_cmd_q;
  dft_pkg::step_t base_q;
  dft_pkg::step_t step_q;
  dft_pkg::step_t phase_q;
  logic issue;
  logic iss_last_n;
  logic iss_last_k;
  logic load;

  logic [2*dft_pkg::DATA_W-1:0] x_q;
  dft_pkg::coef_t cos_q;
  dft_pkg::coef_t sin_q;
  dft_pkg::mac_ctl_s ctl_q;
  dft_pkg::out_beat_s res;
  logic [dft_pkg::LUT_W-1:0] lut_idx;

  assign take = in_i.valid;
  assign start = take & in_i.sop;
  assign start_len = dft_pkg::len_of(in_i.cmd);
  assign frame_done = take & ~in_i.sop & wr_active_q & ~wr_drop_q
                      & (wr_addr_q == wr_len_q - 12'h001);

  // Start marker restarts framing; command captured only here
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_active_q <= 1'b0;
      wr_drop_q <= 1'b0;
      wr_addr_q <= '0;
      wr_len_q <= dft_pkg::LEN_TAB[0];
      wr_cmd_q <= '0;
    end else if (start) begin
      wr_active_q <= 1'b1;
      wr_drop_q <= bank_full_q[wr_bank_q];
      wr_addr_q <= 12'h001;
      wr_len_q <= start_len;
      wr_cmd_q <= in_i.cmd;
    end else if (take && wr_active_q) begin
      wr_addr_q <= wr_addr_q + 12'h001;
      if (wr_addr_q == wr_len_q - 12'h001) begin
        wr_active_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_bank_q <= 1'b0;
    end else if (frame_done) begin
      wr_bank_q <= ~wr_bank_q;
    end
  end

  // Both banks busy: the new transform is dropped, never stalled
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      drop_o <= 1'b0;
    end else begin
      drop_o <= start & bank_full_q[wr_bank_q];
    end
  end

  assign mem_we = start ? ~bank_full_q[wr_bank_q] : (take & wr_active_q & ~wr_drop_q);
  assign mem_waddr = {wr_bank_q, start ? 12'h000 : wr_addr_q};

  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      frame_mem[mem_waddr] <= {in_i.re, in_i.im};
    end
  end

  // Two banks in ping-pong order keep transforms in input order
  for (genvar b = 0; b < dft_pkg::BANKS; b++) begin : g_bank
    logic set_b;
    logic clr_b;
    assign set_b = frame_done & (wr_bank_q == 1'(b));
    assign clr_b = issue & iss_last_n & iss_last_k & (rd_bank_q == 1'(b));
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        bank_full_q[b] <= 1'b0;
      end else begin
        bank_full_q[b] <= set_b | (bank_full_q[b] & ~clr_b);
      end
    end
    always_ff @(posedge clk_i) begin
      if (set_b) begin
        bank_cmd_q[b] <= wr_cmd_q;
      end
    end
  end

  assign issue = (state_q == dft_pkg::ENG_RUN);
  assign iss_last_n = (n_q == rd_len_q - 12'h001);
  assign iss_last_k = (k_q == rd_len_q - 12'h001);
  assign load = (state_q == dft_pkg::ENG_IDLE) & bank_full_q[rd_bank_q];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= dft_pkg::ENG_IDLE;
      rd_bank_q <= 1'b0;
    end else begin
      case (state_q)
        dft_pkg::ENG_IDLE: begin
          if (load) begin
            state_q <= dft_pkg::ENG_RUN;
          end
        end
        dft_pkg::ENG_RUN: begin
          if (iss_last_n && iss_last_k) begin
            state_q <= dft_pkg::ENG_IDLE;
            rd_bank_q <= ~rd_bank_q;
          end
        end
        default: begin
          state_q <= dft_pkg::ENG_IDLE;
        end
      endcase
    end
  end

  // Bin k walks phase n*k/N in steps; one bin costs N cycles
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      n_q <= '0;
      k_q <= '0;
      rd_len_q <= dft_pkg::LEN_TAB[0];
      rd_cmd_q <= '0;
      base_q <= '0;
      step_q <= '0;
      phase_q <= '0;
    end else if (load) begin
      n_q <= '0;
      k_q <= '0;
      rd_len_q <= dft_pkg::len_of(bank_cmd_q[rd_bank_q]);
      rd_cmd_q <= bank_cmd_q[rd_bank_q];
      base_q <= dft_pkg::step_of(bank_cmd_q[rd_bank_q]);
      step_q <= '0;
      phase_q <= '0;
    end else if (issue) begin
      if (iss_last_n) begin
        n_q <= '0;
        k_q <= k_q + 12'h001;
        phase_q <= '0;
        step_q <= step_q + base_q;
      end else begin
        n_q <= n_q + 12'h001;
        phase_q <= phase_q + step_q;
      end
    end
  end

  assign lut_idx = phase_q[dft_pkg::PH_W-1 -: dft_pkg::LUT_W];

  always_ff @(posedge clk_i) begin
    x_q <= frame_mem[{rd_bank_q, n_q}];
    cos_q <= dft_pkg::COS_TAB[lut_idx];
    // Inverse uses the conjugate twiddle
    if (rd_cmd_q[dft_pkg::DIR_BIT]) begin
      sin_q <= -dft_pkg::COS_TAB[lut_idx - dft_pkg::QUARTER];
    end else begin
      sin_q <= dft_pkg::COS_TAB[lut_idx - dft_pkg::QUARTER];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctl_q <= '0;
    end else begin
      ctl_q.valid <= issue;
      ctl_q.first <= n_q == '0;
      ctl_q.last <= iss_last_n;
      ctl_q.sop <= k_q == '0;
      ctl_q.cmd <= rd_cmd_q;
    end
  end

  dft_mac dft_mac_inst (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ctl_i(ctl_q),
    .xr_i(x_q[2*dft_pkg::DATA_W-1 -: dft_pkg::DATA_W]),
    .xi_i(x_q[dft_pkg::DATA_W-1:0]),
    .c_i(cos_q),
    .s_i(sin_q),
    .res_o(res)
  );

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      out_o <= '0;
    end else begin
      out_o <= res;
    end
  end

  // Helpers for the checks below
  logic seen_q;
  dft_pkg::len_t ocnt_q;
  dft_pkg::len_t olen_q;
  dft_pkg::cmd_t ocmd_q;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      seen_q <= 1'b0;
      ocnt_q <= '0;
      olen_q <= '0;
      ocmd_q <= '0;
    end else if (out_o.valid) begin
      seen_q <= 1'b1;
      ocnt_q <= out_o.sop ? 12'h001 : ocnt_q + 12'h001;
      if (out_o.sop) begin
        olen_q <= dft_pkg::len_of(out_o.cmd);
        ocmd_q <= out_o.cmd;
      end
    end
  end

  AST_OUT_SOP_VALID: assert property (@(posedge clk_i) disable iff (reset_i)
    out_o.sop |-> out_o.valid) else $error("output start without valid");
  AST_FREE_START: assert property (@(posedge clk_i) disable iff (reset_i)
    start && !bank_full_q[wr_bank_q] |=> wr_active_q && !wr_drop_q && !drop_o)
    else $error("free bank did not take a new transform");
  AST_CMD_CAPTURE: assert property (@(posedge clk_i) disable iff (reset_i)
    start |=> wr_cmd_q == $past(in_i.cmd)) else $error("command not captured at start");
  AST_CMD_IGNORED: assert property (@(posedge clk_i) disable iff (reset_i)
    !start |=> $stable(wr_cmd_q)) else $error("command changed without start");
  AST_SKIP_INVALID: assert property (@(posedge clk_i) disable iff (reset_i)
    !in_i.valid |=> $stable(wr_addr_q) && $stable(wr_active_q))
    else $error("invalid cycle advanced the frame");
  AST_ENGINE_START: assert property (@(posedge clk_i) disable iff (reset_i)
    load |=> issue && n_q == '0 && k_q == '0) else $error("engine did not start");
  AST_FIRST_OUT: assert property (@(posedge clk_i) disable iff (reset_i)
    issue && iss_last_n && k_q == '0 |-> ##4 out_o.valid && out_o.sop)
    else $error("first result not after fixed overhead");
  AST_EMPTY_LATENCY: assert property (@(posedge clk_i) disable iff (reset_i)
    frame_done && state_q == dft_pkg::ENG_IDLE && bank_full_q == '0 |-> ##2 issue && n_q == '0)
    else $error("empty pipeline did not start at once");
  AST_IN_ORDER: assert property (@(posedge clk_i) disable iff (reset_i)
    out_o.valid && out_o.sop && seen_q |-> ocnt_q == olen_q)
    else $error("transform started before previous one finished");
  AST_BIN_COUNT: assert property (@(posedge clk_i) disable iff (reset_i)
    out_o.valid && !out_o.sop |-> seen_q && ocnt_q < olen_q)
    else $error("too many results in a transform");
  AST_CMD_FOLLOWS: assert property (@(posedge clk_i) disable iff (reset_i)
    out_o.valid && !out_o.sop |-> out_o.cmd == ocmd_q)
    else $error("command changed within a transform");

  COV_BACK_TO_BACK: cover property (@(posedge clk_i) disable iff (reset_i)
    frame_done ##1 start);
  COV_DROP: cover property (@(posedge clk_i) disable iff (reset_i) drop_o);
  COV_INVERSE_OUT: cover property (@(posedge clk_i) disable iff (reset_i)
    out_o.sop && out_o.cmd[dft_pkg::DIR_BIT]);
  COV_QUEUED: cover property (@(posedge clk_i) disable iff (reset_i)
    frame_done && state_q == dft_pkg::ENG_RUN);
endmodule

// ===== shared/dft_pkg.sv
package dft_pkg;
  localparam int DATA_W = 16;
  localparam int LEN_W = 12;
  localparam int IDX_W = 6;
  localparam int CMD_W = 7;
  localparam int DIR_BIT = 6;
  localparam int ACC_W = 48;
  localparam int OUT_W = 32;
  localparam int OUT_LSB = 15;
  localparam int LUT_W = 10;
  localparam int LUT_DEPTH = 1024;
  localparam int PH_W = 32;
  localparam int BANKS = 2;
  localparam int SIZES = 53;
  localparam logic [LUT_W-1:0] QUARTER = 10'h100;
  localparam logic [IDX_W-1:0] NUM_SIZES = 6'h35;
  // Cycles from the last issue of a bin to its result at the top output
  localparam int ISSUE_TO_OUT = 4;
  // Cycles beyond the first bin's N issue cycles from the last input sample to the first output, empty pipeline
  localparam int PIPE_OVERHEAD = 5;

  typedef logic [CMD_W-1:0] cmd_t;
  typedef logic [LEN_W-1:0] len_t;
  typedef logic [PH_W-1:0] step_t;
  typedef logic signed [DATA_W-1:0] coef_t;
  typedef len_t len_tab_t [0:SIZES-1];
  typedef step_t step_tab_t [0:SIZES-1];
  typedef coef_t cos_tab_t [0:LUT_DEPTH-1];

  localparam len_tab_t LEN_TAB = '{
    12'h00c, 12'h018, 12'h024, 12'h030, 12'h03c, 12'h048, 12'h060, 12'h06c,
    12'h078, 12'h090, 12'h0b4, 12'h0c0, 12'h0d8, 12'h0f0, 12'h120, 12'h12c,
    12'h144, 12'h168, 12'h180, 12'h1b0, 12'h1e0, 12'h21c, 12'h240, 12'h258,
    12'h288, 12'h2d0, 12'h300, 12'h360, 12'h384, 12'h3c0, 12'h3cc, 12'h438,
    12'h480, 12'h4b0, 12'h510, 12'h5a0, 12'h5dc, 12'h600, 12'h654, 12'h6c0,
    12'h708, 12'h780, 12'h798, 12'h870, 12'h900, 12'h960, 12'ha20, 12'ha8c,
    12'hb40, 12'hb64, 12'hbb8, 12'hc00, 12'hca8};

  // Phase step per sample for bin 1, a fraction of a full turn
  function automatic step_tab_t build_steps();
    step_tab_t t;
    for (int i = 0; i < SIZES; i++) begin
      t[i] = PH_W'((64'h0000_0001_0000_0000 + 64'(LEN_TAB[i] / 2)) / 64'(LEN_TAB[i]));
    end
    return t;
  endfunction

  function automatic cos_tab_t build_cos();
    cos_tab_t t;
    real a;
    for (int i = 0; i < LUT_DEPTH; i++) begin
      a = 32767.0 * $cos(6.283185307179586 * i / 1024.0);
      t[i] = coef_t'($rtoi(a < 0.0 ? a - 0.5 : a + 0.5));
    end
    return t;
  endfunction

  localparam step_tab_t STEP_TAB = build_steps();
  localparam cos_tab_t COS_TAB = build_cos();

  // Out-of-range size indices fall back to the first length
  function automatic len_t len_of(cmd_t cmd);
    logic [IDX_W-1:0] idx;
    idx = cmd[IDX_W-1:0];
    return (idx < NUM_SIZES) ? LEN_TAB[idx] : LEN_TAB[0];
  endfunction

  function automatic step_t step_of(cmd_t cmd);
    logic [IDX_W-1:0] idx;
    idx = cmd[IDX_W-1:0];
    return (idx < NUM_SIZES) ? STEP_TAB[idx] : STEP_TAB[0];
  endfunction

  typedef struct packed {
    logic valid;
    logic sop;
    cmd_t cmd;
    logic signed [DATA_W-1:0] re;
    logic signed [DATA_W-1:0] im;
  } in_beat_s;

  typedef struct packed {
    logic valid;
    logic sop;
    cmd_t cmd;
    logic signed [OUT_W-1:0] re;
    logic signed [OUT_W-1:0] im;
  } out_beat_s;

  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic sop;
    cmd_t cmd;
  } mac_ctl_s;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b01,
    ENG_RUN  = 2'b10
  } eng_state_e;
endpackage

// ===== core/dft_mac.sv
`timescale 1ns/10ps
module dft_mac (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire dft_pkg::mac_ctl_s ctl_i,
  input wire logic signed [dft_pkg::DATA_W-1:0] xr_i,
  input wire logic signed [dft_pkg::DATA_W-1:0] xi_i,
  input wire logic signed [dft_pkg::DATA_W-1:0] c_i,
  input wire logic signed [dft_pkg::DATA_W-1:0] s_i,
  output dft_pkg::out_beat_s res_o
);
  logic signed [32:0] pr_q;
  logic signed [32:0] pi_q;
  dft_pkg::mac_ctl_s pctl_q;
  logic signed [dft_pkg::ACC_W-1:0] acc_re_q;
  logic signed [dft_pkg::ACC_W-1:0] acc_im_q;
  logic signed [dft_pkg::ACC_W-1:0] sum_re;
  logic signed [dft_pkg::ACC_W-1:0] sum_im;

  // Sample times conjugated twiddle; s_i already carries the direction
  always_ff @(posedge clk_i) begin
    pr_q <= 33'(xr_i * c_i) + 33'(xi_i * s_i);
    pi_q <= 33'(xi_i * c_i) - 33'(xr_i * s_i);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pctl_q <= '0;
    end else begin
      pctl_q <= ctl_i;
    end
  end

  always_comb begin
    sum_re = (pctl_q.first ? '0 : acc_re_q) + dft_pkg::ACC_W'(pr_q);
    sum_im = (pctl_q.first ? '0 : acc_im_q) + dft_pkg::ACC_W'(pi_q);
  end

  // Wide accumulator: the longest length cannot overflow it
  always_ff @(posedge clk_i) begin
    if (pctl_q.valid) begin
      acc_re_q <= sum_re;
      acc_im_q <= sum_im;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      res_o <= '0;
    end else begin
      res_o.valid <= pctl_q.valid & pctl_q.last;
      res_o.sop <= pctl_q.valid & pctl_q.last & pctl_q.sop;
      res_o.cmd <= pctl_q.cmd;
      res_o.re <= sum_re[dft_pkg::OUT_LSB +: dft_pkg::OUT_W];
      res_o.im <= sum_im[dft_pkg::OUT_LSB +: dft_pkg::OUT_W];
    end
  end
endmodule

// ===== verification/dft_source.sv
`timescale 1ns/10ps
module dft_source (
  input wire logic clk_i,
  output dft_pkg::in_beat_s beat_o
);
  int seed = 32'hdf4a_de9c;
  int xr [0:3239];
  int xi [0:3239];
  longint last_t;

  initial beat_o = '0;

  // One frame; gap_pct out of 256 is the share of idle cycles inside it
  task automatic send_frame(input dft_pkg::cmd_t cmd, input int n, input int gap_pct);
    int i;
    i = 0;
    while (i < n) begin
      @(posedge clk_i);
      if (i > 0 && (($random(seed) & 255) < gap_pct)) begin
        // Idle data changes so a stale beat never looks valid
        beat_o <= '{valid: 1'b0, sop: 1'b0, cmd: 7'($random(seed)),
                    re: 16'($random(seed)), im: 16'($random(seed))};
      end else begin
        xr[i] = $random(seed) % 2048;
        xi[i] = $random(seed) % 2048;
        // Command only meaningful with the start marker; junk elsewhere
        beat_o <= '{valid: 1'b1, sop: (i == 0), cmd: (i == 0) ? cmd : ~cmd,
                    re: 16'(xr[i]), im: 16'(xi[i])};
        i++;
      end
    end
    last_t = longint'($time) + 8;
  endtask

  task automatic go_idle();
    @(posedge clk_i);
    beat_o <= '{valid: 1'b0, sop: 1'b0, cmd: ~beat_o.cmd, re: ~beat_o.re, im: ~beat_o.im};
  endtask
endmodule

// ===== verification/dft_stream_tb.sv
`timescale 1ns/10ps
module dft_stream_tb;
  typedef struct {
    dft_pkg::cmd_t cmd;
    logic sop;
    longint re;
    longint im;
    longint t;
  } note_s;

  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  dft_pkg::in_beat_s in_beat;
  dft_pkg::out_beat_s out_beat;
  logic drop;
  note_s exp_q [$];
  int mismatches = 0;
  int total_checks = 0;
  int drops_seen = 0;
  int drops_want = 0;
  // Twiddles are coarse, so results are matched within a band
  int tol = 768;

  always #4 clk_i = ~clk_i;

  dft_stream dft_stream_inst (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_i(in_beat),
    .out_o(out_beat),
    .drop_o(drop)
  );

  dft_source dft_source_inst (
    .clk_i(clk_i),
    .beat_o(in_beat)
  );

  task automatic check(input logic [63:0] seen, input logic [63:0] want, input int slack);
    longint d;
    total_checks++;
    d = longint'(seen) - longint'(want);
    if ($isunknown(seen) || d > slack || d < -slack) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Reference sums in floating point, forward or inverse by the top bit
  task automatic expect_frame(input dft_pkg::cmd_t cmd, input int n, input bit timed);
    real ar;
    real ai;
    real th;
    real sg;
    note_s e;
    sg = cmd[dft_pkg::DIR_BIT] ? -1.0 : 1.0;
    for (int k = 0; k < n; k++) begin
      ar = 0.0;
      ai = 0.0;
      for (int m = 0; m < n; m++) begin
        th = 6.283185307179586 * ((m * k) % n) / n;
        ar += dft_source_inst.xr[m] * $cos(th) + sg * dft_source_inst.xi[m] * $sin(th);
        ai += dft_source_inst.xi[m] * $cos(th) - sg * dft_source_inst.xr[m] * $sin(th);
      end
      e.cmd = cmd;
      e.sop = (k == 0);
      e.re = longint'(ar);
      e.im = longint'(ai);
      e.t = timed ? dft_source_inst.last_t + (dft_pkg::PIPE_OVERHEAD + (k + 1) * n) * 8 : 0;
      exp_q.push_back(e);
    end
  endtask

  task automatic run(input dft_pkg::cmd_t cmd, input int gap, input bit timed, input bit kept);
    int n;
    n = (cmd[5:0] < dft_pkg::NUM_SIZES) ? int'(dft_pkg::LEN_TAB[cmd[5:0]])
                                        : int'(dft_pkg::LEN_TAB[0]);
    dft_source_inst.send_frame(cmd, n, gap);
    if (kept) begin
      expect_frame(cmd, n, timed);
    end else begin
      drops_want++;
    end
  endtask

  task automatic drain();
    dft_source_inst.go_idle();
    for (int w = 0; w < 20000 && exp_q.size() > 0; w++) begin
      @(posedge clk_i);
    end
    check(64'(exp_q.size()), 64'h0, 0);
    repeat (4) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    note_s e;
    if (drop === 1'b1) begin
      drops_seen++;
    end
    if (out_beat.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(64'(out_beat.valid), 64'h0, 0);
      end else begin
        e = exp_q.pop_front();
        check(64'(out_beat.cmd), 64'(e.cmd), 0);
        check(64'(out_beat.sop), 64'(e.sop), 0);
        check(64'(out_beat.re), e.re, tol);
        check(64'(out_beat.im), e.im, tol);
        if (e.t != 0) check(64'($time), 64'(e.t), 0);
      end
    end
  end

  initial begin
    fork
      begin
        repeat (40000) @(posedge clk_i);
        mismatches++;
        give_verdict();
      end
    join_none
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(64'(out_beat), 64'h0, 0);
    run(7'h00, 0, 1'b1, 1'b1);
    drain();
    run(7'h40, 0, 1'b1, 1'b1);
    drain();
    for (int i = 1; i < 3; i++) begin
      run(7'(i), 0, 1'b1, 1'b1);
      drain();
    end
    // Unmapped index, inverse, idle cycles and junk commands mid-frame
    run(7'h7f, 64, 1'b1, 1'b1);
    drain();
    // Longer transform first, shorter one straight after it
    run(7'h01, 0, 1'b1, 1'b1);
    run(7'h40, 16, 1'b0, 1'b1);
    drain();
    // Third frame finds both banks held and is discarded
    run(7'h00, 0, 1'b1, 1'b1);
    run(7'h00, 0, 1'b0, 1'b1);
    run(7'h02, 0, 1'b0, 1'b0);
    drain();
    check(64'(drops_seen), 64'(drops_want), 0);
    give_verdict();
  end
endmodule
